//--- core/inc_unit_consts.svh
// Purpose: constants of the increment unit: register offsets, resets, flag bits, costs
// Assumes: included by the unit and by its flag calculator
// Notes: costs are core clock cycles and program words
// How it works
// - long increment on memory writes back only the low 32 bits of the sum
// - long form: extension flag set when guard bits of 36-bit result in use
// - long form: unnormalized flag set when the 36-bit result is unnormalized
// - long form: negative is result bit 31; zero when the whole result is zero
// - long form: carry set on a carry out of result bit 31
// - both forms: overflow flag set when the addition overflows the result
// - long cost: register 1 cycle 1 word, short absolute 3/2, long absolute 4/3
// - word form adds one to a 16-bit register or memory word, writes it back
// - word form on an accumulator increments guard and middle word only
// - word flags from the 20-bit result on accumulators, else from 16 bits
// - word carry out of bit 15, or out of bit 35 on accumulators
// - word zero flag; accumulators test only the upper 20 bits
// - word negative from result msb; extension when guard portion in use
// - word limit flag on move saturation or overflow; size flag from the move
// - parallel move reads memory into a register, or writes pm_wdata to memory, and post-increments the pointer
// - word increment with parallel move takes one word and one cycle
// - word cost: reg 1/1, indirect 3/1, offset 4/2, stack 4/1, abs 3/2 and 4/3
`ifndef INC_UNIT_CONSTS_SVH
`define INC_UNIT_CONSTS_SVH
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_RES_LO 8'h08
`define OFF_RES_HI 8'h0C
`define OFF_COUNT 8'h10
`define CTRL_EN_BIT 0
`define CTRL_EN_RESET 1'b1
`define FLG_C 0
`define FLG_V 1
`define FLG_Z 2
`define FLG_N 3
`define FLG_U 4
`define FLG_GUARD 5
`define FLG_LIM 6
`define FLG_SIZE 7
`define C_REG 3'h1
`define W_REG 2'h1
`define C_IND 3'h3
`define W_IND 2'h1
`define C_IOFF 3'h4
`define W_IOFF 2'h2
`define C_SPOFF 3'h4
`define W_SPOFF 2'h1
`define C_ABSS 3'h3
`define W_ABSS 2'h2
`define C_ABSL 3'h4
`define W_ABSL 2'h3
`endif

//--- core/inc_pkg.sv
// Purpose: types of the increment unit
// Assumes: constants live in inc_unit_consts.svh
// Notes: state_t holds every register of the unit
package inc_pkg;
   typedef enum logic {OP_LONG, OP_WORD} op_t;
   typedef enum logic [1:0] {DST_ACC, DST_REG, DST_MEM} dst_t;
   typedef enum logic [2:0] {AM_IND, AM_IND_OFF, AM_SP_OFF, AM_ABS_SHORT, AM_ABS_LONG} am_t;
   typedef enum logic {ST_IDLE, ST_RUN} fsm_t;
   typedef struct packed {
      fsm_t fsm;
      logic [2:0] cnt;
      logic [2:0] tot;
      logic [1:0] wrd;
      op_t op;
      dst_t dst;
      logic pm;
      logic pm_wr;
      logic [23:0] addr;
      logic [35:0] res;
      logic [7:0] flg;
      logic [15:0] stat;
      logic lim;
      logic size;
      logic pm_pend;
      logic pm_we;
      logic pm_areg_we;
      logic [2:0] pm_dst;
      logic [15:0] pm_data;
      logic [2:0] pm_areg;
      logic [23:0] pm_aval;
      logic en;
      logic [15:0] ops;
      logic [31:0] prdata;
   } state_t;
endpackage

//--- core/inc_flag_calc.sv
// Purpose: sum and condition flags of the long and word increments
// Assumes: operand already selected; memory long operands arrive in the low 32 bits
// Notes: purely combinational
`timescale 1ns/10ps
`include "inc_unit_consts.svh"
module inc_flag_calc (
   input wire inc_pkg::op_t op,
   input wire inc_pkg::dst_t dst,
   input wire logic [35:0] opnd,
   input wire logic [7:0] flg_in,
   input wire logic lim_in,
   input wire logic size_in,
   output logic [35:0] res,
   output logic [7:0] flg
);
   import inc_pkg::*;

   always_comb begin
      logic [35:0] x;
      x = (dst == DST_ACC) ? opnd : {{4{opnd[31]}}, opnd[31:0]};
      res = x;
      flg = flg_in;
      if (op == OP_LONG) begin
         res = x + 36'h1;
         flg[`FLG_GUARD] = ~(&res[35:31] | ~|res[35:31]);
         flg[`FLG_U] = ~(res[31] ^ res[30]);
         flg[`FLG_N] = res[31];
         flg[`FLG_Z] = ~|res;
         flg[`FLG_C] = &x[31:0];
         flg[`FLG_V] = (dst == DST_ACC) ? (x == 36'h7_FFFF_FFFF)
                                        : (x[31:0] == 32'h7FFF_FFFF);
      end else if (dst == DST_ACC) begin
         // low word passes through untouched
         res = {opnd[35:16] + 20'h1, opnd[15:0]};
         flg[`FLG_C] = &opnd[35:16];
         flg[`FLG_V] = (opnd[35:16] == 20'h7_FFFF);
         flg[`FLG_N] = res[35];
         flg[`FLG_Z] = ~|res[35:16];
         flg[`FLG_GUARD] = ~(&res[35:31] | ~|res[35:31]);
         flg[`FLG_U] = ~(res[31] ^ res[30]);
         flg[`FLG_LIM] = flg_in[`FLG_LIM] | lim_in | flg[`FLG_V];
         flg[`FLG_SIZE] = flg_in[`FLG_SIZE] | size_in;
      end else begin
         res = {20'h0, opnd[15:0] + 16'h1};
         flg[`FLG_C] = &opnd[15:0];
         flg[`FLG_V] = (opnd[15:0] == 16'h7FFF);
         flg[`FLG_N] = res[15];
         flg[`FLG_Z] = ~|res[15:0];
         flg[`FLG_GUARD] = 1'b0;
         flg[`FLG_U] = ~(res[15] ^ res[14]);
         flg[`FLG_LIM] = flg_in[`FLG_LIM] | lim_in | flg[`FLG_V];
         flg[`FLG_SIZE] = flg_in[`FLG_SIZE] | size_in;
      end
   end

endmodule // inc_flag_calc

//--- core/increment_long_word_unit.sv
// Purpose: long and word increment execution with memory sequencing and flags
// Assumes: memory read data valid exactly one cycle after mem_rd
// Notes: registers on APB; one state struct, one comb and one clocked process
`timescale 1ns/10ps
`include "inc_unit_consts.svh"
module increment_long_word_unit (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic start,
   output logic ready,
   input wire inc_pkg::op_t op,
   input wire inc_pkg::dst_t dst,
   input wire inc_pkg::am_t am,
   input wire logic [35:0] opnd,
   input wire logic [23:0] addr,
   input wire logic [15:0] status_in,
   input wire logic lim_in,
   input wire logic size_in,
   input wire logic pm_en,
   input wire logic pm_wr,
   input wire logic [15:0] pm_wdata,
   input wire logic [2:0] pm_dst,
   input wire logic [2:0] pm_areg,
   input wire logic [23:0] pm_aval,
   input wire logic [23:0] pm_step,
   output logic done,
   output logic res_we,
   output logic [35:0] result,
   output logic [15:0] status_out,
   output logic [2:0] cyc_cost,
   output logic [1:0] word_cost,
   output logic mem_rd,
   output logic mem_wr,
   output logic mem_long,
   output logic [23:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   output logic pm_we,
   output logic [2:0] pm_dst_out,
   output logic [15:0] pm_data,
   output logic pm_areg_we,
   output logic [2:0] pm_areg_out,
   output logic [23:0] pm_aval_out
);
   import inc_pkg::*;

   state_t s_q;
   state_t s_d;
   logic take;
   logic run;
   logic mem_op;
   logic capture;
   logic pm_access;
   logic known;
   op_t c_op;
   dst_t c_dst;
   logic [35:0] c_in;
   logic [7:0] c_flg_in;
   logic c_lim;
   logic c_size;
   logic [35:0] c_res;
   logic [7:0] c_flg;

   ////////////////////////////////////////////////////////////////////////////
   // cycle and word cost per addressing mode, {cycles, words}
   function automatic logic [4:0] cost(dst_t d, am_t a);
      logic [4:0] c;
      c = {`C_REG, `W_REG};
      if (d == DST_MEM) begin
         case (a)
            AM_IND: c = {`C_IND, `W_IND};
            AM_IND_OFF: c = {`C_IOFF, `W_IOFF};
            AM_SP_OFF: c = {`C_SPOFF, `W_SPOFF};
            AM_ABS_SHORT: c = {`C_ABSS, `W_ABSS};
            default: c = {`C_ABSL, `W_ABSL};
         endcase
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // sequencing strobes
   // a pending parallel access holds off the next start so its outputs stay stable
   assign ready = (s_q.fsm == ST_IDLE) && s_q.en && !s_q.pm_pend;
   assign take = start && ready;
   assign run = (s_q.fsm == ST_RUN);
   assign mem_op = (s_q.dst == DST_MEM);
   assign pm_access = run && s_q.pm && (s_q.cnt == 3'h1);
   assign capture = run && mem_op && (s_q.cnt == s_q.tot - 3'h1);
   assign done = run && (s_q.cnt == s_q.tot);
   // read, add, then write back in the finishing cycle
   assign mem_rd = (pm_access && !s_q.pm_wr)
                   || (run && mem_op && (s_q.cnt == s_q.tot - 3'h2));
   assign mem_wr = (done && mem_op) || (pm_access && s_q.pm_wr);
   assign mem_long = run && (s_q.op == OP_LONG) && mem_op;
   // long operand address passes as given; its evenness is the caller's duty
   assign mem_addr = s_q.addr;
   // only the low 32 bits of a long sum go back to memory
   assign mem_wdata = (s_q.pm && s_q.pm_wr) ? {16'h0, s_q.pm_data} : s_q.res[31:0];
   assign res_we = done && !mem_op;
   assign result = s_q.res;
   assign status_out = s_q.stat;
   assign cyc_cost = s_q.tot;
   assign word_cost = s_q.wrd;
   assign pm_we = s_q.pm_we;
   assign pm_dst_out = s_q.pm_dst;
   assign pm_data = s_q.pm_data;
   assign pm_areg_we = s_q.pm_areg_we;
   assign pm_areg_out = s_q.pm_areg;
   assign pm_aval_out = s_q.pm_aval;

   ////////////////////////////////////////////////////////////////////////////
   // flag calculator: decoder operand at take, memory data at capture
   assign c_op = take ? op : s_q.op;
   assign c_dst = take ? dst : s_q.dst;
   assign c_in = take ? opnd : {4'h0, mem_rdata};
   assign c_flg_in = take ? status_in[7:0] : s_q.stat[7:0];
   assign c_lim = take ? lim_in : s_q.lim;
   assign c_size = take ? size_in : s_q.size;

   inc_flag_calc calc (
      .op(c_op),
      .dst(c_dst),
      .opnd(c_in),
      .flg_in(c_flg_in),
      .lim_in(c_lim),
      .size_in(c_size),
      .res(c_res),
      .flg(c_flg)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, error on unmapped addresses
   assign known = (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS) || (paddr == `OFF_RES_LO)
                  || (paddr == `OFF_RES_HI) || (paddr == `OFF_COUNT);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !known;
   assign prdata = s_q.prdata;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d = s_q;
      s_d.pm_we = 1'b0;
      s_d.pm_areg_we = 1'b0;
      s_d.pm_pend = pm_access;
      if (s_q.pm_pend) begin
         s_d.pm_areg_we = 1'b1;
         if (!s_q.pm_wr) begin
            s_d.pm_we = 1'b1;
            s_d.pm_data = mem_rdata[15:0];
         end
      end
      case (s_q.fsm)
         ST_IDLE: begin
            if (take) begin
               s_d.fsm = ST_RUN;
               s_d.cnt = 3'h1;
               {s_d.tot, s_d.wrd} = cost(dst, am);
               s_d.op = op;
               s_d.dst = dst;
               s_d.pm = pm_en;
               s_d.pm_wr = pm_wr;
               s_d.stat = status_in;
               s_d.lim = lim_in;
               s_d.size = size_in;
               s_d.addr = pm_en ? pm_aval : addr;
               if (pm_en) begin
                  s_d.pm_dst = pm_dst;
                  s_d.pm_areg = pm_areg;
                  s_d.pm_aval = pm_aval + pm_step;
                  s_d.pm_data = pm_wdata;
               end
               if (dst != DST_MEM) begin
                  s_d.res = c_res;
                  s_d.flg = c_flg;
               end
            end
         end
         ST_RUN: begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (capture) begin
               s_d.res = c_res;
               s_d.flg = c_flg;
            end
            if (done) begin
               s_d.fsm = ST_IDLE;
               s_d.ops = s_q.ops + 16'h1;
               // mode byte kept, flags final only after the write back
               s_d.stat = {s_q.stat[15:8], s_q.flg};
            end
         end
         default: s_d.fsm = ST_IDLE;
      endcase
      if (psel && !penable) begin
         if (paddr == `OFF_CTRL) begin
            s_d.prdata = {31'h0, s_q.en};
         end else if (paddr == `OFF_STATUS) begin
            s_d.prdata = {9'h0, s_q.tot, 1'b0, s_q.wrd, run, s_q.stat};
         end else if (paddr == `OFF_RES_LO) begin
            s_d.prdata = s_q.res[31:0];
         end else if (paddr == `OFF_RES_HI) begin
            s_d.prdata = {28'h0, s_q.res[35:32]};
         end else if (paddr == `OFF_COUNT) begin
            s_d.prdata = {16'h0, s_q.ops};
         end else begin
            s_d.prdata = 32'h0;
         end
      end
      if (psel && penable && pwrite) begin
         if (paddr == `OFF_CTRL) begin
            s_d.en = pwdata[`CTRL_EN_BIT];
         end else if (paddr == `OFF_COUNT) begin
            s_d.ops = (done ? 16'h1 : 16'h0);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.en <= `CTRL_EN_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_reg_one_cycle: assert property ((take && dst != DST_MEM) |-> ##1 (done && res_we))
      else $error("register increment did not finish in one cycle");
   a_pm_one_cycle: assert property ((take && pm_en) |-> ##1 (done && !mem_op))
      else $error("parallel move form took more than one cycle");
   a_mem_three_cyc: assert property ((take && dst == DST_MEM && (am == AM_IND
      || am == AM_ABS_SHORT)) |-> ##1 mem_rd ##1 !done ##1 (mem_wr && done))
      else $error("three cycle memory sequence broken");
   a_mem_four_cyc: assert property ((take && dst == DST_MEM && !(am == AM_IND
      || am == AM_ABS_SHORT)) |-> ##1 !mem_rd ##1 mem_rd ##1 !done ##1 (mem_wr && done))
      else $error("four cycle memory sequence broken");
   a_long_wdata: assert property ((mem_wr && !s_q.pm && s_q.op == OP_LONG)
      |-> (mem_wdata == $past(mem_rdata) + 32'h1 && $past(mem_rd, 2)))
      else $error("long memory write back is not read value plus one");
   a_word_wdata: assert property ((mem_wr && !s_q.pm && s_q.op == OP_WORD)
      |-> mem_wdata[15:0] == $past(mem_rdata[15:0]) + 16'h1)
      else $error("word memory write back is not read value plus one");
   a_acc_low_kept: assert property ((take && op == OP_WORD && dst == DST_ACC)
      |=> (result[15:0] == $past(opnd[15:0])
      && result[35:16] == $past(opnd[35:16]) + 20'h1))
      else $error("word accumulator increment touched the low word");
   a_mode_byte: assert property (take |-> ##2 status_out[15:8] == $past(status_in[15:8], 2))
      else $error("mode byte changed");
   a_word_carry: assert property ((take && op == OP_WORD && dst == DST_REG
      && opnd[15:0] == 16'hFFFF) |-> ##2 (status_out[`FLG_C] && status_out[`FLG_Z]))
      else $error("word carry or zero flag wrong");
   a_long_zero: assert property ((take && op == OP_LONG && dst == DST_ACC
      && opnd == 36'hF_FFFF_FFFF) |-> ##2 (status_out[`FLG_Z] && !status_out[`FLG_N]
      && status_out[`FLG_C]))
      else $error("long zero result flags wrong");
   a_acc_overflow: assert property ((take && op == OP_WORD && dst == DST_ACC
      && opnd[35:16] == 20'h7_FFFF) |-> ##2 (status_out[`FLG_V] && status_out[`FLG_LIM]))
      else $error("word accumulator overflow not flagged");
   a_pm_post_inc: assert property ((take && pm_en) |-> ##3 (pm_areg_we
      && pm_aval_out == $past(pm_aval, 3) + $past(pm_step, 3)))
      else $error("parallel move pointer not post incremented");

   c_long_mem: cover property (take && op == OP_LONG && dst == DST_MEM);
   c_pm_read: cover property (take && pm_en && !pm_wr ##3 pm_we);
   c_word_acc: cover property (take && op == OP_WORD && dst == DST_ACC);
   c_apb_write: cover property (psel && penable && pwrite && paddr == `OFF_CTRL);

endmodule // increment_long_word_unit

//--- test/data_mem_model.sv
// Purpose: data memory on the far side of the increment unit
// Assumes: read data is due exactly one cycle after a read strobe
// Notes: outside that cycle the bus shows the inverse of its last value
`timescale 1ns/10ps
module data_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [23:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic [23:0] wr_addr,
   output logic [31:0] wr_data
);
   logic [31:0] mem [0:255];
   logic rd_q;
   logic [7:0] a_q;
   logic [31:0] last_q;
   //////////////////////////////////////////////////////////////////
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_q <= 1'b0;
         a_q <= 8'h00;
         last_q <= 32'h0;
      end else begin
         rd_q <= mem_rd;
         a_q <= mem_addr[7:0];
         if (rd_q) begin
            last_q <= mem_rdata;
         end
         if (mem_wr) begin
            mem[mem_addr[7:0]] <= mem_wdata;
            wr_addr <= mem_addr;
            wr_data <= mem_wdata;
         end
      end
   end
   // data only in the cycle after a read, so a late capture sees garbage
   assign mem_rdata = rd_q ? mem[a_q] : ~last_q;
endmodule // data_mem_model

//--- test/tb_increment_long_word_unit.sv
// Purpose: self-checking bench of the increment unit
// Assumes: memory answers one cycle after a read; APB slave answers at once
// Notes: register, memory, parallel-move and register-bus scenarios
`timescale 1ns/10ps
`define CHECK_EQ(nm, ex, got) \
   begin \
      n_compared++; \
      if ((got) !== (ex)) begin \
         failures++; \
         $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
      end \
   end
module tb_increment_long_word_unit;
   import inc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, mem_wdata, mem_rdata, wr_data, r;
   logic pready, pslverr, ready, done, res_we, mem_rd, mem_wr, mem_long, pm_we, pm_areg_we;
   op_t op = OP_WORD;
   dst_t dst = DST_REG;
   am_t am = AM_IND;
   logic [35:0] opnd = 36'h0, result, d_res;
   logic [23:0] addr = 24'h0, pm_aval = 24'h0, pm_step = 24'h0, mem_addr, pm_aval_out, wr_addr;
   logic [15:0] status_in = 16'h0, pm_wdata = 16'h0, status_out, pm_data;
   logic lim_in = 1'b0, size_in = 1'b0, pm_en = 1'b0, pm_wr = 1'b0, e, d_rwe, d_mwr, d_mlg;
   logic [2:0] pm_dst = 3'h0, pm_areg = 3'h0, cyc_cost, pm_dst_out, pm_areg_out;
   logic [1:0] word_cost;
   int failures = 0, n_compared = 0, c;
   op_t top [9] = '{OP_WORD, OP_WORD, OP_WORD, OP_WORD, OP_LONG, OP_LONG, OP_LONG, OP_WORD,
      OP_LONG};
   dst_t tdst [9] = '{DST_REG, DST_REG, DST_ACC, DST_ACC, DST_ACC, DST_ACC, DST_REG, DST_ACC,
      DST_ACC};
   logic [35:0] tin [9] = '{36'h7FFF, 36'hFFFF, 36'h0_FFFF_0033, 36'hF_FFFF_1234,
      36'h0_FFFF_FFFF, 36'h7_FFFF_FFFF, 36'h1, 36'h7_FFFF_0000, 36'hF_FFFF_FFFF};
   logic [35:0] tout [9] = '{36'h8000, 36'h0, 36'h1_0000_0033, 36'h0_0000_1234,
      36'h1_0000_0000, 36'h8_0000_0000, 36'h2, 36'h8_0000_0000, 36'h0};
   logic [7:0] tfl [9] = '{8'h4A, 8'h15, 8'h30, 8'h15, 8'h31, 8'h33, 8'h10, 8'h7A, 8'h15};
   op_t mop [7] = '{OP_WORD, OP_WORD, OP_WORD, OP_WORD, OP_WORD, OP_LONG, OP_LONG};
   am_t mam [7] = '{AM_IND, AM_IND_OFF, AM_SP_OFF, AM_ABS_SHORT, AM_ABS_LONG, AM_ABS_SHORT,
      AM_ABS_LONG};
   int mcy [7] = '{3, 4, 4, 3, 4, 3, 4};
   int mwd [7] = '{1, 2, 1, 2, 3, 2, 3};
   //////////////////////////////////////////////////////////////////
   increment_long_word_unit i_increment_long_word_unit (.clk(clk), .rst(rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .start(start), .ready(ready), .op(op), .dst(dst),
      .am(am), .opnd(opnd), .addr(addr), .status_in(status_in), .lim_in(lim_in),
      .size_in(size_in), .pm_en(pm_en), .pm_wr(pm_wr), .pm_wdata(pm_wdata), .pm_dst(pm_dst),
      .pm_areg(pm_areg), .pm_aval(pm_aval), .pm_step(pm_step), .done(done), .res_we(res_we),
      .result(result), .status_out(status_out), .cyc_cost(cyc_cost), .word_cost(word_cost),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_long(mem_long), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pm_we(pm_we), .pm_dst_out(pm_dst_out),
      .pm_data(pm_data), .pm_areg_we(pm_areg_we), .pm_areg_out(pm_areg_out),
      .pm_aval_out(pm_aval_out));
   data_mem_model i_data_mem_model (.clk(clk), .rst(rst), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .wr_addr(wr_addr),
      .wr_data(wr_data));
   //////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // issue one instruction, wait for done, return one cycle after it
   task automatic go(input op_t o, input dst_t d, input am_t m, input logic [35:0] v,
      input logic [23:0] a, input logic p);
      @(posedge clk);
      op <= o;
      dst <= d;
      am <= m;
      opnd <= v;
      addr <= a;
      pm_en <= p;
      start <= 1'b1;
      #1;
      `CHECK_EQ("ready", 1'b1, ready)
      @(posedge clk);
      start <= 1'b0;
      c = 0;
      while (c < 8) begin
         #1;
         c++;
         if (done === 1'b1) break;
         @(posedge clk);
      end
      d_rwe = res_we;
      d_mwr = mem_wr;
      d_mlg = mem_long;
      d_res = result;
      @(posedge clk);
      #1;
   endtask
   task automatic t_reg_table();
      logic [35:0] m;
      logic [15:0] s;
      for (int i = 0; i < 9; i++) begin
         s = (top[i] == OP_LONG) ? 16'h5AC0 : 16'h5A00;
         @(posedge clk);
         status_in <= s;
         go(top[i], tdst[i], AM_IND, tin[i], 24'h0, 1'b0);
         m = (tdst[i] == DST_ACC) ? '1 : (top[i] == OP_LONG) ? 36'hFFFF_FFFF : 36'hFFFF;
         `CHECK_EQ("cycles", 1, c)
         `CHECK_EQ("costs", 5'b001_01, {cyc_cost, word_cost})
         `CHECK_EQ("res_we", 1'b1, d_rwe)
         `CHECK_EQ("result", tout[i] & m, d_res & m)
         `CHECK_EQ("status", s | {8'h00, tfl[i]}, status_out)
      end
      $display("test register destinations done");
   endtask
   task automatic t_mem_modes();
      logic [23:0] a;
      logic lng;
      for (int i = 0; i < 7; i++) begin
         a = 24'h10 + 24'(2 * i); // even operand addresses only
         lng = (mop[i] == OP_LONG);
         i_data_mem_model.mem[a[7:0]] = lng ? 32'hFFFF_FFFF : 32'h0000_1233;
         @(posedge clk);
         status_in <= lng ? 16'h5AC0 : 16'h5A00;
         go(mop[i], DST_MEM, mam[i], 36'h0, a, 1'b0);
         `CHECK_EQ("cycles", mcy[i], c)
         `CHECK_EQ("costs", {3'(mcy[i]), 2'(mwd[i])}, {cyc_cost, word_cost})
         `CHECK_EQ("write strobes", {2'b10, lng}, {d_mwr, d_rwe, d_mlg})
         `CHECK_EQ("write addr", a, wr_addr)
         `CHECK_EQ("write data", lng ? 32'h0 : 32'h1234, wr_data & (lng ? '1 : 32'hFFFF))
         `CHECK_EQ("status", lng ? 16'h5AD5 : 16'h5A10, status_out)
      end
      $display("test memory modes done");
   endtask
   task automatic t_parallel();
      i_data_mem_model.mem[8'h40] = 32'h0000_BEEF;
      @(posedge clk);
      status_in <= 16'h5A00;
      lim_in <= 1'b1;
      size_in <= 1'b1;
      pm_aval <= 24'h40;
      pm_step <= 24'h3;
      pm_dst <= 3'h5; // read target differs from the accumulator
      pm_areg <= 3'h2;
      go(OP_WORD, DST_ACC, AM_IND, 36'h0_0001_0000, 24'h0, 1'b1);
      `CHECK_EQ("cycles", 1, c)
      `CHECK_EQ("result", 36'h0_0002_0000, d_res)
      `CHECK_EQ("status", 16'h5AD0, status_out)
      `CHECK_EQ("ready gap", 1'b0, ready)
      @(posedge clk);
      #1;
      `CHECK_EQ("move", {2'b11, 16'hBEEF, 3'h5, 3'h2}, {pm_we, pm_areg_we, pm_data, pm_dst_out, pm_areg_out})
      `CHECK_EQ("pointer", 24'h43, pm_aval_out)
      // parallel write of pm_wdata to memory at the pointer, pointer register updated, no pm_dst load
      @(posedge clk);
      pm_wr <= 1'b1;
      pm_wdata <= 16'hA5C3;
      go(OP_WORD, DST_ACC, AM_IND, 36'h0_0001_0000, 24'h0, 1'b1);
      `CHECK_EQ("move strobes", 2'b11, {d_mwr, d_rwe})
      `CHECK_EQ("move wdata", {24'h40, 32'h0000_A5C3}, {wr_addr, wr_data})
      @(posedge clk);
      #1;
      `CHECK_EQ("write no load", 2'b01, {pm_we, pm_areg_we})
      $display("test parallel move done");
   endtask
   task automatic t_regs();
      apb(1'b0, 8'h00, 32'h0);
      `CHECK_EQ("ctrl reset", 33'h0_0000_0001, {e, r})
      apb(1'b1, 8'h00, 32'h0);
      @(posedge clk);
      start <= 1'b1;
      repeat (3) begin
         @(posedge clk);
         #1;
         `CHECK_EQ("refused", 2'b00, {ready, done})
      end
      @(posedge clk);
      start <= 1'b0;
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b0, 8'h14, 32'h0);
      `CHECK_EQ("unmapped", 33'h1_0000_0000, {e, r})
      apb(1'b0, 8'h04, 32'h0);
      `CHECK_EQ("status reg", 32'h0012_5AD0, r)
      apb(1'b0, 8'h08, 32'h0);
      `CHECK_EQ("result reg", 32'h0002_0000, r)
      apb(1'b0, 8'h10, 32'h0);
      `CHECK_EQ("count", 16'd18, r[15:0])
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      `CHECK_EQ("count clear", 16'd0, r[15:0])
      $display("test register bus done");
   endtask
   //////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      #20000;
      failures++;
      stop_test();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reg_table();
      t_mem_modes();
      t_parallel();
      t_regs();
      stop_test();
   end
endmodule // tb_increment_long_word_unit
